//--- design/gdp_map.vh
`ifndef GDP_MAP_VH
`define GDP_MAP_VH
// register indices; byte address on the bus is four times the index
`define GDP_IDX_FIRST_DATA     8'h05
`define GDP_IDX_SECOND_DATA    8'h06
`define GDP_IDX_INTR_CTRL      8'h0b
`define GDP_IDX_OPTION         8'h81
`define GDP_IDX_FIRST_DIR      8'h85
`define GDP_IDX_SECOND_DIR     8'h86
`define GDP_IDX_CONV_CTRL1     8'h9f
// field positions
`define GDP_OPT_PULLUP_N_BIT   7
`define GDP_INTR_CHG_FLAG_BIT  0
`define GDP_FIRST_OD_BIT       4
`define GDP_FIRST_SS_BIT       5
`define GDP_SECOND_EXT_INT_BIT 0
`define GDP_SECOND_PGM_CLK_BIT 6
`define GDP_SECOND_PGM_DAT_BIT 7
// reset values
`define GDP_RST_FIRST_DIR      6'h3f
`define GDP_RST_SECOND_DIR     8'hff
`define GDP_RST_OPTION         8'hff
`define GDP_RST_CONV_CTRL1     3'h0
`define GDP_RST_INTR_CTRL      8'h00
`define GDP_RST_LATCH6         6'h00
`define GDP_RST_LATCH8         8'h00
`endif

//--- design/gdp_sync.v
`default_nettype none
module gdp_sync #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         rst,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge clk) begin
        if (rst) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule
`default_nettype wire

//--- design/gdp_chg.v
`default_nettype none
module gdp_chg #(
    parameter W = 4
) (
    input  wire         clk,
    input  wire         rst,
    input  wire [W-1:0] pins,
    input  wire [W-1:0] is_input,
    input  wire         relatch,
    output wire         mismatch
);
    reg [W-1:0] old_q;

    // comparison latch refreshed on every access of the port
    always @(posedge clk) begin
        if (rst) begin
            old_q <= {W{1'b0}};
        end else if (relatch) begin
            old_q <= pins;
        end
    end

    // outputs never count, only pins set as inputs
    assign mismatch = |((pins ^ old_q) & is_input);
endmodule
`default_nettype wire

//--- design/gdp_top.v
// Functional notes
// - first port holds a six-bit output latch, upper two bits absent.
// - first port direction bit set floats the driver, clear drives latch.
// - first port read returns pin levels, write updates only the latch.
// - port writes behave as read-modify-write into the output latch; the code loads the written bus byte into the latch as is.
// - first port bit four is open drain and feeds the timer clock.
// - other first port pins go analog or digital per three-bit field.
// - after power-on analog pins default analog and read zero.
// - direction bits still steer drivers on analog pins; software keeps them set.
// - first port data and direction bits seven and six read zero.
// - second port is eight bits bidirectional with per-pin direction.
// - option bit seven cleared enables all second port weak pull-ups.
// - a pin's pull-up turns off while that pin is an output.
// - pull-ups are disabled after power-on reset.
// - only upper-nibble input pins take part in change detection.
// - upper pins compared with values latched at the last port access, read or write, set change flag bit zero.
// - a pending change flag can wake the device from sleep.
// - mismatch keeps setting the flag; port access ends it, software clears.
// - early silicon may drop a change coinciding with a port read.
// - second port bit zero is also the external interrupt input.
// - second port bits six and seven serve serial programming clock, data.
// - first port bit five also gives the serial port slave select.
//
// Design decision made here: the Wishbone register port.
`include "gdp_map.vh"
`default_nettype none
module gdp_top #(
    parameter EARLY_SILICON = 0
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [9:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire        wb_ack_o,
    input  wire [5:0]  first_port_in,
    output wire [5:0]  first_port_out,
    output wire [5:0]  first_port_oe,
    output wire [4:0]  analog_pin_en,
    output wire        vref_pin_en,
    output wire        timer_ext_clock_in,
    output wire        slave_select_in,
    input  wire [7:0]  second_port_in,
    output wire [7:0]  second_port_out,
    output wire [7:0]  second_port_oe,
    output wire [7:0]  second_port_pullup,
    output wire        ext_interrupt_in,
    output wire        pgm_clock_in,
    output wire        pgm_data_in,
    output wire        port_change_flag,
    output wire        wake_req
);
    reg  [5:0]  first_latch_q;
    reg  [5:0]  first_latch_d;
    reg  [5:0]  first_dir_q;
    reg  [5:0]  first_dir_d;
    reg  [2:0]  conv_cfg_q;
    reg  [2:0]  conv_cfg_d;
    reg  [7:0]  second_latch_q;
    reg  [7:0]  second_latch_d;
    reg  [7:0]  second_dir_q;
    reg  [7:0]  second_dir_d;
    reg  [7:0]  option_q;
    reg  [7:0]  option_d;
    reg  [7:0]  intr_ctrl_q;
    reg  [7:0]  intr_ctrl_d;
    reg  [7:0]  rdata_q;
    reg  [7:0]  rdata_d;
    reg         ack_q;
    reg  [4:0]  analog_mask;
    reg         vref_sel;
    wire [5:0]  first_sync;
    wire [7:0]  second_sync;
    wire [5:0]  first_digital;
    wire [5:0]  first_analog;
    wire        first_od_oe;
    wire [7:0]  idx;
    wire        req;
    wire        wr;
    wire        rd;
    wire        lane0;
    wire        second_access;
    wire        second_read;
    wire        mismatch;
    wire        chg_set;

    // two-stage sync of every pin input
    // synchronize pin inputs
    gdp_sync #(
        .W(6)
    ) u_sync_first (
        .clk      (clk),
        .rst      (rst),
        .async_in (first_port_in),
        .sync_out (first_sync)
    );

    gdp_sync #(
        .W(8)
    ) u_sync_second (
        .clk      (clk),
        .rst      (rst),
        .async_in (second_port_in),
        .sync_out (second_sync)
    );

    // classic wishbone: one wait state, ack lasts one cycle
    // req drops in the ack cycle so a strobe held over ack is not taken twice
    assign req   = wb_cyc_i & wb_stb_i & ~ack_q;
    assign idx   = wb_adr_i[9:2];
    assign wr    = req & wb_we_i;
    assign rd    = req & ~wb_we_i;
    assign lane0 = wb_sel_i[0];

    // analog field decode; ordering is [bit5, bit3, bit2, bit1, bit0]
    // analog or digital select
    always @* begin
        analog_mask = 5'h00;
        vref_sel    = 1'b0;
        case (conv_cfg_q)
            3'h0: begin
                analog_mask = 5'h1f;
            end
            3'h1: begin
                analog_mask = 5'h1f;
                vref_sel    = 1'b1;
            end
            3'h2: begin
                analog_mask = 5'h0f;
            end
            3'h3: begin
                analog_mask = 5'h0f;
                vref_sel    = 1'b1;
            end
            3'h4: begin
                analog_mask = 5'h0b;
            end
            3'h5: begin
                analog_mask = 5'h0b;
                vref_sel    = 1'b1;
            end
            default: begin
                analog_mask = 5'h00;
            end
        endcase
    end

    assign analog_pin_en = analog_mask;
    assign vref_pin_en   = vref_sel;

    // pin four has no analog function, so its mask slot is always clear
    assign first_analog = {analog_mask[4], 1'b0, analog_mask[3:0]};

    // analog pins read as zero on the digital path
    // analog pins read zero
    assign first_digital = first_sync & ~first_analog;

    assign timer_ext_clock_in = first_sync[`GDP_FIRST_OD_BIT];
    assign slave_select_in = first_sync[`GDP_FIRST_SS_BIT];
    assign ext_interrupt_in = second_sync[`GDP_SECOND_EXT_INT_BIT];
    assign pgm_clock_in = second_sync[`GDP_SECOND_PGM_CLK_BIT];
    assign pgm_data_in  = second_sync[`GDP_SECOND_PGM_DAT_BIT];

    // drivers; direction still governs analog pins, software keeps them set
    // first port drivers
    assign first_port_out = {first_latch_q[5], 1'b0, first_latch_q[3:0]};
    // open drain pulls low only
    // a latched one floats the pin, so only an external pull-up lifts it
    assign first_od_oe    = ~first_dir_q[4] & ~first_latch_q[4];
    assign first_port_oe  = {~first_dir_q[5], first_od_oe, ~first_dir_q[3:0]};

    assign second_port_out = second_latch_q;
    assign second_port_oe  = ~second_dir_q;
    // pull-up off on outputs
    // a driving pin would only waste current through its own pull-up
    assign second_port_pullup = {8{~option_q[`GDP_OPT_PULLUP_N_BIT]}} & second_dir_q;

    assign second_access = req & (idx == `GDP_IDX_SECOND_DATA);
    assign second_read   = second_access & ~wb_we_i;

    // compare and relatch share the synced copy, so one sample feeds both
    // upper-nibble inputs only
    gdp_chg #(
        .W(4)
    ) u_chg (
        .clk      (clk),
        .rst      (rst),
        .pins     (second_sync[7:4]),
        .is_input (second_dir_q[7:4]),
        .relatch  (second_access),
        .mismatch (mismatch)
    );

    // early variants lose a change landing on the read cycle
    // early silicon read race
    // off by default: later silicon keeps every change
    assign chg_set = mismatch & ~((EARLY_SILICON != 0) & second_read);

    // register writes; the port latches take the written bus byte whole
    always @* begin
        first_latch_d  = first_latch_q;
        first_dir_d    = first_dir_q;
        conv_cfg_d     = conv_cfg_q;
        second_latch_d = second_latch_q;
        second_dir_d   = second_dir_q;
        option_d       = option_q;
        intr_ctrl_d    = intr_ctrl_q;
        if (wr && lane0) begin
            case (idx)
                `GDP_IDX_FIRST_DATA: begin
                    first_latch_d = wb_dat_i[5:0];
                end
                `GDP_IDX_FIRST_DIR: begin
                    first_dir_d = wb_dat_i[5:0];
                end
                `GDP_IDX_CONV_CTRL1: begin
                    conv_cfg_d = wb_dat_i[2:0];
                end
                `GDP_IDX_SECOND_DATA: begin
                    second_latch_d = wb_dat_i[7:0];
                end
                `GDP_IDX_SECOND_DIR: begin
                    second_dir_d = wb_dat_i[7:0];
                end
                `GDP_IDX_OPTION: begin
                    option_d = wb_dat_i[7:0];
                end
                `GDP_IDX_INTR_CTRL: begin
                    intr_ctrl_d = wb_dat_i[7:0];
                end
                default: begin
                    first_latch_d = first_latch_q;
                end
            endcase
        end
        // set wins over a software clear in the same cycle
        // mismatch sets flag
        if (chg_set) begin
            intr_ctrl_d[`GDP_INTR_CHG_FLAG_BIT] = 1'b1;
        end
    end

    // read mux; unmapped indices read zero
    always @* begin
        rdata_d = 8'h00;
        case (idx)
            `GDP_IDX_FIRST_DATA: begin
                rdata_d = {2'b00, first_digital};
            end
            `GDP_IDX_FIRST_DIR: begin
                rdata_d = {2'b00, first_dir_q};
            end
            `GDP_IDX_CONV_CTRL1: begin
                rdata_d = {5'h00, conv_cfg_q};
            end
            `GDP_IDX_SECOND_DATA: begin
                rdata_d = second_sync;
            end
            `GDP_IDX_SECOND_DIR: begin
                rdata_d = second_dir_q;
            end
            `GDP_IDX_OPTION: begin
                rdata_d = option_q;
            end
            `GDP_IDX_INTR_CTRL: begin
                rdata_d = intr_ctrl_q;
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            first_latch_q  <= `GDP_RST_LATCH6;
            conv_cfg_q     <= `GDP_RST_CONV_CTRL1;
            first_dir_q    <= `GDP_RST_FIRST_DIR;
            second_latch_q <= `GDP_RST_LATCH8;
            second_dir_q   <= `GDP_RST_SECOND_DIR;
            option_q       <= `GDP_RST_OPTION;
            intr_ctrl_q    <= `GDP_RST_INTR_CTRL;
            rdata_q        <= 8'h00;
            ack_q          <= 1'b0;
        end else begin
            first_latch_q  <= first_latch_d;
            first_dir_q    <= first_dir_d;
            conv_cfg_q     <= conv_cfg_d;
            second_latch_q <= second_latch_d;
            second_dir_q   <= second_dir_d;
            option_q       <= option_d;
            intr_ctrl_q    <= intr_ctrl_d;
            ack_q          <= req;
            // read data holds until the next read is taken
            if (rd) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = {24'h000000, rdata_q};

    assign port_change_flag = intr_ctrl_q[`GDP_INTR_CHG_FLAG_BIT];
    // pending change raises a wake request to the sleep controller
    // wake from sleep
    assign wake_req = intr_ctrl_q[`GDP_INTR_CHG_FLAG_BIT];
endmodule
`default_nettype wire

//--- bench/gdp_checker.sv
`include "gdp_map.vh"
`default_nettype none
module gdp_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [9:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [5:0]  first_port_in,
    input wire logic [5:0]  first_port_out,
    input wire logic [5:0]  first_port_oe,
    input wire logic [4:0]  analog_pin_en,
    input wire logic        timer_ext_clock_in,
    input wire logic        slave_select_in,
    input wire logic [7:0]  second_port_in,
    input wire logic [7:0]  second_port_oe,
    input wire logic [7:0]  second_port_pullup,
    input wire logic        ext_interrupt_in,
    input wire logic        pgm_clock_in,
    input wire logic        pgm_data_in,
    input wire logic        port_change_flag,
    input wire logic        wake_req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [1:0] up_q;
    wire        clr_w;
    // synchronizers hold reset values for two edges, so compare only after that
    always @(posedge clk) begin
        if (rst)
            up_q <= 2'h0;
        else if (up_q != 2'h3)
            up_q <= up_q + 2'h1;
    end
    assign clr_w = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
                   && wb_adr_i[9:2] == `GDP_IDX_INTR_CTRL;
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_follows: assert property (s_req |=> s_answer)
        else $error("ack not a single pulse one cycle after request");
    a_read_high_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_od_low_only: assert property (!first_port_out[4])
        else $error("open drain pin driven high");
    a_pullup_off_out: assert property ((second_port_pullup & second_port_oe) == 8'h00)
        else $error("pull-up on while pin drives");
    a_first_pins_sync: assert property (up_q == 2'h3 |->
        {slave_select_in, timer_ext_clock_in} == $past(first_port_in[5:4], 2))
        else $error("first port alternate inputs not two edges late");
    a_second_pins_sync: assert property (up_q == 2'h3 |->
        {pgm_data_in, pgm_clock_in} == $past(second_port_in[7:6], 2)
        && ext_interrupt_in == $past(second_port_in[0], 2))
        else $error("second port alternate inputs not two edges late");
    a_flag_held: assert property (port_change_flag && !clr_w |=> port_change_flag)
        else $error("change flag dropped without a clear");
    a_wake_flag: assert property (wake_req == port_change_flag)
        else $error("wake request differs from change flag");
    a_reset_state: assert property ($fell(rst) |-> second_port_pullup == 8'h00
        && first_port_oe == 6'h00 && second_port_oe == 8'h00 && analog_pin_en == 5'h1f)
        else $error("outputs wrong after reset");
endmodule
bind gdp_top gdp_checker chk_u (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_o, .wb_ack_o, .first_port_in, .first_port_out, .first_port_oe,
    .analog_pin_en, .timer_ext_clock_in, .slave_select_in, .second_port_in, .second_port_oe,
    .second_port_pullup, .ext_interrupt_in, .pgm_clock_in, .pgm_data_in, .port_change_flag,
    .wake_req);
`default_nettype wire

//--- bench/gdp_pins.sv
`default_nettype none
module gdp_pins (
    input  wire logic       clk,
    input  wire logic [5:0] a_out,
    input  wire logic [5:0] a_oe,
    input  wire logic [5:0] a_en,
    input  wire logic [5:0] a_val,
    input  wire logic [7:0] b_out,
    input  wire logic [7:0] b_oe,
    input  wire logic [7:0] b_pu,
    input  wire logic [7:0] b_en,
    input  wire logic [7:0] b_val,
    output var  logic [5:0] a_pin,
    output var  logic [7:0] b_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tog_q = 1'b0;
    // a floating pin toggles each clock so that a stale value cannot keep reading as a match
    always @(posedge clk) begin
        tog_q <= ~tog_q;
    end
    always_comb begin
        for (int i = 0; i < 6; i++)
            a_pin[i] = a_oe[i] ? a_out[i] : (a_en[i] ? a_val[i] : tog_q);
        for (int i = 0; i < 8; i++)
            b_pin[i] = b_oe[i] ? b_out[i] : (b_en[i] ? b_val[i] : (b_pu[i] | tog_q));
    end
endmodule
`default_nettype wire

//--- bench/test_gdp_top.sv
`default_nettype none
module test_gdp_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [9:0]  adr = 10'h000;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0, r;
    logic [5:0]  a_en = 6'h3f, a_val = 6'h3f;
    logic [7:0]  b_en = 8'hff, b_val = 8'h00;
    logic [5:0]  atab [8] = '{6'h1f, 6'h3f, 6'h0f, 6'h2f, 6'h0b, 6'h2b, 6'h00, 6'h00};
    int          miscompares = 0, n_checks = 0;
    wire [31:0] rdat;
    wire [5:0]  ain, aout, aoe;
    wire [7:0]  bin, bout, boe, bpu;
    wire [4:0]  apen;
    wire        ack, vref, flag, wake, flag_e;
    always #5 clk = ~clk;
    gdp_top dut_u (.clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .first_port_in(ain), .first_port_out(aout), .first_port_oe(aoe), .analog_pin_en(apen),
        .vref_pin_en(vref), .timer_ext_clock_in(), .slave_select_in(), .second_port_in(bin),
        .second_port_out(bout), .second_port_oe(boe), .second_port_pullup(bpu),
        .ext_interrupt_in(), .pgm_clock_in(), .pgm_data_in(), .port_change_flag(flag),
        .wake_req(wake));
    // early variant: same bus and pins, only its change flag is compared
    gdp_top #(.EARLY_SILICON(1)) dut_early_u (.clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(),
        .wb_ack_o(), .first_port_in(ain), .first_port_out(), .first_port_oe(),
        .analog_pin_en(), .vref_pin_en(), .timer_ext_clock_in(), .slave_select_in(),
        .second_port_in(bin), .second_port_out(), .second_port_oe(), .second_port_pullup(),
        .ext_interrupt_in(), .pgm_clock_in(), .pgm_data_in(), .port_change_flag(flag_e),
        .wake_req());
    gdp_pins pins_u (.clk, .a_out(aout), .a_oe(aoe), .a_en, .a_val, .b_out(bout), .b_oe(boe),
        .b_pu(bpu), .b_en, .b_val, .a_pin(ain), .b_pin(bin));
    task results;
        if (miscompares == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task acc(input logic w, input logic [7:0] i, input logic [7:0] d, input logic [3:0] s);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        sel <= s;
        wdat <= {24'h0, d};
        // no cycle count is assumed; the watchdog ends a wait that never answers
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task wr(input logic [7:0] i, input logic [7:0] d);
        acc(1'b1, i, d, 4'h1);
    endtask
    task rc(input logic [7:0] i, input logic [31:0] exp);
        acc(1'b0, i, 8'h00, 4'h1);
        chk(r, exp);
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        results;
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rc(8'h85, 32'h3f);
        rc(8'h9f, 32'h00);
        rc(8'h05, 32'h10);
        rc(8'h81, 32'hff);
        rc(8'h40, 32'h00);
        wr(8'h85, 8'hff);
        rc(8'h85, 32'h3f);
        acc(1'b1, 8'h85, 8'h00, 4'h0);
        rc(8'h85, 32'h3f);
        for (int k = 0; k < 8; k++) begin
            wr(8'h9f, k[7:0]);
            chk({vref, apen}, atab[k]);
        end
        a_en <= 6'h30;
        a_val <= 6'h20;
        wr(8'h05, 8'h15);
        chk(aout, 6'h05);
        wr(8'h85, 8'h30);
        chk(aoe, 6'h0f);
        rc(8'h05, 32'h25);
        wr(8'h85, 8'h00);
        chk(aoe, 6'h2f);
        wr(8'h9f, 8'h00);
        chk(aoe, 6'h2f);
        wr(8'h85, 8'h3f);
        chk(aoe, 6'h00);
        wr(8'h81, 8'h7f);
        wr(8'h86, 8'h0f);
        b_en <= 8'h00;
        chk(bpu, 8'h0f);
        chk(boe, 8'hf0);
        wr(8'h06, 8'ha5);
        chk(bout, 8'ha5);
        repeat (4) @(posedge clk);
        rc(8'h06, 32'haf);
        chk(flag, 1'b0);
        wr(8'h86, 8'hff);
        b_en <= 8'hff;
        wr(8'h81, 8'hff);
        rc(8'h06, 32'h00);
        wr(8'h0b, 8'h00);
        chk(flag, 1'b0);
        // no port reads while changes are watched
        b_val <= 8'h01;
        repeat (4) @(posedge clk);
        chk(flag, 1'b0);
        b_val <= 8'h21;
        repeat (4) @(posedge clk);
        chk({wake, flag}, 2'h3);
        wr(8'h0b, 8'h00);
        chk(flag, 1'b1);
        rc(8'h0b, 32'h01);
        rc(8'h06, 32'h21);
        wr(8'h0b, 8'h00);
        chk(flag, 1'b0);
        b_val <= 8'h61;
        repeat (4) @(posedge clk);
        chk(flag, 1'b1);
        wr(8'h06, 8'h00);
        wr(8'h0b, 8'h00);
        chk(flag, 1'b0);
        // change reaches the compare in the very cycle the read is taken
        b_val <= 8'h41;
        @(posedge clk);
        rc(8'h06, 32'h41);
        chk(flag, 1'b1);
        chk(flag_e, 1'b0);
        results;
    end
endmodule
`default_nettype wire
